//--- common/txport_pkg.sv
// Constants for the transmit frame-sync serial input port.
//==========================================================
// Overview of operation
// - In framed modes other than the mask modes a frame-start edge realigns the frame bit counter.
// - In fractional modes the start-of-frame position follows a rising edge on the frame-start input.
// - Without frame-start edges the counter keeps framing on its own, even with the input stuck.
// - Inputs other than the PLCP overhead port are sampled on the rising edge of the reference clock, or the falling edge when it is inverted.
// - The reference clock is picked from the transmit, line, clock-out, receive-out and receive-line clocks.
// - Each of the five data inputs has its own programmable polarity inversion.
// - In mask modes a low mask sample yields a valid line data bit three reference periods later.
// - The mask input is delayed by exactly three reference periods to time line data and the mask output.
// - In flexible fractional mode the payload bits come from the serial payload input.
// - In PLCP modes with the port on, each overhead bit is replaced by the overhead input while enabled.
// - The PLCP overhead input is sampled on the falling edge of the overhead clock.
// - The overhead start-of-frame output marks the first bit of the PLCP overhead sequence.
// - In fractional modes with the port on, fractional overhead bits come from the fractional input.
package txport_pkg;
    // Register offsets.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] POL_OFS = 8'h04;
    localparam logic [7:0] FLEN_OFS = 8'h08;
    localparam logic [7:0] PLEN_OFS = 8'h0c;
    localparam logic [7:0] STAT_OFS = 8'h10;
    localparam logic [7:0] ACNT_OFS = 8'h14;
    // Control fields.
    localparam int MODE_LSB = 0;
    localparam int PEN_BIT = 3;
    localparam int CSEL_LSB = 4;
    localparam int CINV_BIT = 7;
    // Polarity bit positions.
    localparam int POL_FS = 0;
    localparam int POL_MASK = 1;
    localparam int POL_PAY = 2;
    localparam int POL_PLCP = 3;
    localparam int POL_FRAC = 4;
    // Reset values.
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [4:0] POL_RST = 5'h00;
    localparam logic [15:0] FLEN_RST = 16'h0100;
    localparam logic [7:0] PLEN_RST = 8'h10;
    // Timing.
    localparam int REF_PERIOD_NS = 100;
    localparam int OVH_PERIOD_NS = 800;
    localparam int OVH_HALF_CYC = OVH_PERIOD_NS / (2 * REF_PERIOD_NS);
    localparam int MASK_DELAY = 3;
    localparam int NUM_REF = 5;
    typedef enum logic [2:0] {
        MODE_FRAMED, MODE_OHM, MODE_FRAC_INT, MODE_FRAC_EXT, MODE_FLEX_FRAC, MODE_PLCP
    } mode_t;
endpackage

//--- rtl/bit_sync.sv
// Two-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/100ps
module bit_sync
    import txport_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Levels.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

//--- rtl/mask_delay.sv
// Fixed delay line that shifts once per reference tick.
`timescale 1ns/100ps
module mask_delay
    import txport_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Shift control and data.
    input wire logic en,
    input wire logic d,
    output logic q
);
    logic [MASK_DELAY-1:0] stage_reg;

    // The line resets high so no valid bit is claimed before three real samples.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            stage_reg <= '1;
        end else if (en) begin
            stage_reg <= {stage_reg[MASK_DELAY-2:0], d};
        end
    end

    assign q = stage_reg[MASK_DELAY-1];
endmodule

//--- rtl/tx_frame_sync_port.sv
// Transmit frame-sync, mask and serial input port of one framer port.
`timescale 1ns/100ps
module tx_frame_sync_port
    import txport_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Candidate reference clocks.
    input wire logic tx_clk_in,
    input wire logic tx_line_clk,
    input wire logic tx_clk_out,
    input wire logic rx_clk_out,
    input wire logic rx_line_clk,
    // Transmit input pins.
    input wire logic tx_frame_start_in,
    input wire logic tx_ovh_mask_in,
    input wire logic tx_serial_payload_in,
    input wire logic tx_plcp_ovh_in,
    input wire logic tx_frac_ovh_in,
    input wire logic tx_plcp_ovh_enable,
    input wire logic tx_frac_ovh_enable_in,
    // Transmit output pins.
    output logic tx_line_data_out,
    output logic tx_ovh_mask_out,
    output logic tx_plcp_ovh_clk,
    output logic tx_plcp_ovh_sof_out,
    // Framer side.
    input wire logic line_bit_in,
    input wire logic plcp_bit_in,
    output logic line_bit_take,
    output logic frame_sof,
    output logic payload_bit,
    output logic payload_valid,
    output logic frac_bit,
    output logic frac_valid,
    output logic plcp_bit_out,
    output logic plcp_valid
);
    //==========================================================
    // Registers
    logic [7:0] ctrl_reg;
    logic [4:0] pol_reg;
    logic [15:0] flen_reg;
    logic [7:0] plen_reg;
    logic [15:0] acnt_reg;
    logic [15:0] frame_pos_reg;
    logic [31:0] rdata_next;
    mode_t mode;
    logic port_en;
    logic [2:0] clk_sel;
    logic clk_inv;

    assign mode = mode_t'(ctrl_reg[MODE_LSB+:3]);
    assign port_en = ctrl_reg[PEN_BIT];
    assign clk_sel = ctrl_reg[CSEL_LSB+:3];
    assign clk_inv = ctrl_reg[CINV_BIT];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= CTRL_RST;
            pol_reg <= POL_RST;
            flen_reg <= FLEN_RST;
            plen_reg <= PLEN_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                CTRL_OFS: ctrl_reg <= reg_wdata[7:0];
                POL_OFS: pol_reg <= reg_wdata[4:0];
                FLEN_OFS: flen_reg <= (reg_wdata[15:0] == 16'h0000) ? 16'h0001 : reg_wdata[15:0];
                PLEN_OFS: plen_reg <= (reg_wdata[7:0] == 8'h00) ? 8'h01 : reg_wdata[7:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        rdata_next = 32'h0000_0000;
        case (reg_addr)
            CTRL_OFS: rdata_next = {24'h000000, ctrl_reg};
            POL_OFS: rdata_next = {27'h0000000, pol_reg};
            FLEN_OFS: rdata_next = {16'h0000, flen_reg};
            PLEN_OFS: rdata_next = {24'h000000, plen_reg};
            STAT_OFS: rdata_next = {16'h0000, frame_pos_reg};
            ACNT_OFS: rdata_next = {16'h0000, acnt_reg};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= reg_rd ? rdata_next : 32'h0000_0000;
        end
    end

    //==========================================================
    // Synchronisers and reference tick
    logic [NUM_REF-1:0] ref_s;
    logic [6:0] pin_s;
    logic [NUM_REF-1:0] ref_prev_reg;
    logic [NUM_REF-1:0] ref_edge;
    logic ref_tick;
    logic fs_lvl, mask_lvl, pay_lvl, plcp_lvl, frac_lvl, plcp_en_lvl, frac_en_lvl;

    bit_sync #(.W(NUM_REF)) u_ref_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .d({rx_line_clk, rx_clk_out, tx_clk_out, tx_line_clk, tx_clk_in}),
        .q(ref_s)
    );

    bit_sync #(.W(7)) u_pin_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .d({tx_frac_ovh_enable_in, tx_plcp_ovh_enable, tx_frac_ovh_in, tx_plcp_ovh_in,
            tx_serial_payload_in, tx_ovh_mask_in, tx_frame_start_in}),
        .q(pin_s)
    );

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ref_prev_reg <= '0;
        end else begin
            ref_prev_reg <= ref_s;
        end
    end

    // A clock edge is seen in the direction chosen by the inversion bit.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REF; gi++) begin : g_edge
            assign ref_edge[gi] = clk_inv ? (ref_prev_reg[gi] & ~ref_s[gi])
                                          : (~ref_prev_reg[gi] & ref_s[gi]);
        end
    endgenerate

    // Unused select codes fall back to the transmit clock input.
    assign ref_tick = (clk_sel < 3'(NUM_REF)) ? ref_edge[clk_sel] : ref_edge[0];

    assign fs_lvl = pin_s[0] ^ pol_reg[POL_FS];
    assign mask_lvl = pin_s[1] ^ pol_reg[POL_MASK];
    assign pay_lvl = pin_s[2] ^ pol_reg[POL_PAY];
    assign plcp_lvl = pin_s[3] ^ pol_reg[POL_PLCP];
    assign frac_lvl = pin_s[4] ^ pol_reg[POL_FRAC];
    assign plcp_en_lvl = pin_s[5];
    assign frac_en_lvl = pin_s[6];

    //==========================================================
    // Frame alignment
    logic fs_prev_reg;
    logic fs_rise;
    logic align_mode;
    logic frame_wrap;

    assign align_mode = (mode != MODE_OHM);
    assign fs_rise = ref_tick & fs_lvl & ~fs_prev_reg & align_mode;
    assign frame_wrap = (frame_pos_reg >= flen_reg - 16'h0001);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fs_prev_reg <= 1'b0;
        end else if (ref_tick) begin
            fs_prev_reg <= fs_lvl;
        end
    end

    // A stuck input gives no rise, so the counter simply free-runs.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            frame_pos_reg <= 16'h0000;
            frame_sof <= 1'b0;
            acnt_reg <= 16'h0000;
        end else begin
            frame_sof <= ref_tick & (fs_rise | frame_wrap);
            if (fs_rise) begin
                frame_pos_reg <= 16'h0000;
                acnt_reg <= acnt_reg + 16'h0001;
            end else if (ref_tick) begin
                frame_pos_reg <= frame_wrap ? 16'h0000 : frame_pos_reg + 16'h0001;
            end
        end
    end

    //==========================================================
    // Mask modes
    logic ohm_tick;
    logic mask_tap;

    assign ohm_tick = ref_tick & (mode == MODE_OHM);

    mask_delay u_mask_delay (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .en(ohm_tick),
        .d(mask_lvl),
        .q(mask_tap)
    );

    // Outside the mask modes every tick carries a line bit.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tx_ovh_mask_out <= 1'b1;
            tx_line_data_out <= 1'b0;
            line_bit_take <= 1'b0;
        end else begin
            line_bit_take <= ref_tick & ((mode != MODE_OHM) | ~mask_tap);
            if (ohm_tick) begin
                tx_ovh_mask_out <= mask_tap;
                if (!mask_tap) begin
                    tx_line_data_out <= line_bit_in;
                end
            end else if (ref_tick) begin
                tx_ovh_mask_out <= 1'b0;
                tx_line_data_out <= line_bit_in;
            end
        end
    end

    //==========================================================
    // Payload and fractional overhead
    logic frac_mode;
    assign frac_mode = (mode == MODE_FRAC_INT) | (mode == MODE_FRAC_EXT);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            payload_bit <= 1'b0;
            payload_valid <= 1'b0;
            frac_bit <= 1'b0;
            frac_valid <= 1'b0;
        end else begin
            payload_valid <= ref_tick & (mode == MODE_FLEX_FRAC);
            if (ref_tick & (mode == MODE_FLEX_FRAC)) begin
                payload_bit <= pay_lvl;
            end
            // External fractional mode takes only the bits the enable marks.
            frac_valid <= ref_tick & port_en & frac_mode & ((mode == MODE_FRAC_INT) | frac_en_lvl);
            if (ref_tick & port_en & frac_mode) begin
                frac_bit <= frac_lvl;
            end
        end
    end

    //==========================================================
    // PLCP overhead clock and port
    logic [7:0] div_reg;
    logic [7:0] plcp_pos_reg;
    logic ovh_fall;
    logic plcp_on;

    assign plcp_on = (mode == MODE_PLCP) & port_en;
    assign ovh_fall = plcp_on & tx_plcp_ovh_clk & (div_reg == 8'(OVH_HALF_CYC - 1));

    // The overhead clock is made here, so its edges are known without sampling.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div_reg <= 8'h00;
            tx_plcp_ovh_clk <= 1'b0;
        end else if (!plcp_on) begin
            div_reg <= 8'h00;
            tx_plcp_ovh_clk <= 1'b0;
        end else if (div_reg == 8'(OVH_HALF_CYC - 1)) begin
            div_reg <= 8'h00;
            tx_plcp_ovh_clk <= ~tx_plcp_ovh_clk;
        end else begin
            div_reg <= div_reg + 8'h01;
        end
    end

    // Outside logic changes data on the rising edge, half a period before this sample.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            plcp_pos_reg <= 8'h00;
            tx_plcp_ovh_sof_out <= 1'b0;
            plcp_bit_out <= 1'b0;
            plcp_valid <= 1'b0;
        end else begin
            plcp_valid <= ovh_fall;
            if (!plcp_on) begin
                plcp_pos_reg <= 8'h00;
                tx_plcp_ovh_sof_out <= 1'b0;
            end else if (ovh_fall) begin
                plcp_bit_out <= plcp_en_lvl ? plcp_lvl : plcp_bit_in;
                plcp_pos_reg <= (plcp_pos_reg >= plen_reg - 8'h01) ? 8'h00 : plcp_pos_reg + 8'h01;
                tx_plcp_ovh_sof_out <= (plcp_pos_reg >= plen_reg - 8'h01);
            end
        end
    end

    //==========================================================
    // Checks
    sequence s_ovh_fall_enabled;
        ovh_fall && plcp_en_lvl;
    endsequence

    sequence s_bit_replaced;
        plcp_valid && plcp_bit_out == $past(plcp_lvl);
    endsequence

    property p_align_edge;
        @(posedge ref_clk) disable iff (!rstn) fs_rise |=> frame_pos_reg == 16'h0000 && frame_sof;
    endproperty
    a_align_edge: assert property (p_align_edge) else $error("frame not realigned on edge");
    property p_frac_align;
        @(posedge ref_clk) disable iff (!rstn)
            (ref_tick && frac_mode && fs_lvl && !fs_prev_reg) |=> frame_sof;
    endproperty
    a_frac_align: assert property (p_frac_align) else $error("fractional sof missed");
    property p_free_run;
        @(posedge ref_clk) disable iff (!rstn)
            (ref_tick && !fs_rise && !frame_wrap && !reg_wr) |=> frame_pos_reg == $past(frame_pos_reg) + 16'h0001;
    endproperty
    a_free_run: assert property (p_free_run) else $error("frame counter stalled");
    property p_tick_dir;
        @(posedge ref_clk) disable iff (!rstn)
            (ref_tick && clk_sel == 3'h0) |-> ref_s[0] == !clk_inv && ref_prev_reg[0] == clk_inv;
    endproperty
    a_tick_dir: assert property (p_tick_dir) else $error("sampled on wrong edge");
    property p_no_tick_other;
        @(posedge ref_clk) disable iff (!rstn)
            (clk_sel == 3'h1 && ref_s[1] == ref_prev_reg[1]) |-> !ref_tick;
    endproperty
    a_no_tick_other: assert property (p_no_tick_other) else $error("tick from unselected clock");
    property p_mask_out;
        @(posedge ref_clk) disable iff (!rstn) ohm_tick |=> tx_ovh_mask_out == $past(mask_tap);
    endproperty
    a_mask_out: assert property (p_mask_out) else $error("mask output not delayed line");
    property p_ohm_data;
        @(posedge ref_clk) disable iff (!rstn)
            (ohm_tick && !mask_tap) |=> tx_line_data_out == $past(line_bit_in) && line_bit_take;
    endproperty
    a_ohm_data: assert property (p_ohm_data) else $error("no valid bit after low mask");

    property p_payload;
        @(posedge ref_clk) disable iff (!rstn)
            (ref_tick && mode == MODE_FLEX_FRAC) |=> payload_valid && payload_bit == $past(pay_lvl);
    endproperty
    a_payload: assert property (p_payload) else $error("payload bit not taken");

    property p_plcp_replace;
        @(posedge ref_clk) disable iff (!rstn) s_ovh_fall_enabled |=> s_bit_replaced;
    endproperty
    a_plcp_replace: assert property (p_plcp_replace) else $error("overhead bit not replaced");

    property p_plcp_fall;
        @(posedge ref_clk) disable iff (!rstn) ovh_fall |=> !tx_plcp_ovh_clk;
    endproperty
    a_plcp_fall: assert property (p_plcp_fall) else $error("overhead sampled off falling edge");

    property p_plcp_sof;
        @(posedge ref_clk) disable iff (!rstn)
            (ovh_fall && plcp_pos_reg == plen_reg - 8'h01) |=> tx_plcp_ovh_sof_out && plcp_pos_reg == 8'h00;
    endproperty
    a_plcp_sof: assert property (p_plcp_sof) else $error("sof not on first overhead bit");

    property p_frac;
        @(posedge ref_clk) disable iff (!rstn)
            (ref_tick && port_en && mode == MODE_FRAC_INT) |=> frac_valid && frac_bit == $past(frac_lvl);
    endproperty
    a_frac: assert property (p_frac) else $error("fractional bit not taken");
endmodule

//--- dv/tx_port_partner.sv
// Far-side transmit logic model: link clock, data pins and overhead port.
`timescale 1ns/100ps
module tx_port_partner (
    // Link clock routing.
    input wire logic [2:0] sel,
    input wire logic inv,
    output logic [4:0] rclk,
    output logic samp_clk,
    // Link data pins.
    output logic mask,
    output logic pay,
    output logic frac,
    output logic fen,
    // Overhead port.
    input wire logic oclk,
    output logic od,
    output logic oen
);
    logic link;
    // The link clock runs free, unrelated in phase to the system clock.
    initial begin
        link = 1'b0;
        {mask, pay, frac, fen, od, oen} = 6'h00;
        #37;
        forever #400 link = ~link;
    end
    assign samp_clk = link ^ inv;
    always_comb begin
        rclk = 5'h00;
        if (sel < 3'h5) begin
            rclk[sel] = link;
        end
    end
    // Data moves on the edge opposite the sampling edge, giving half a period of setup and hold.
    always @(negedge samp_clk) begin
        mask <= 1'($urandom);
        pay <= 1'($urandom);
        frac <= 1'($urandom);
        fen <= 1'($urandom);
    end
    always @(posedge oclk) begin
        od <= 1'($urandom);
        oen <= 1'($urandom);
    end
endmodule

//--- dv/tx_frame_sync_port_tb.sv
// Self-checking bench for the transmit frame-sync serial input port.
`timescale 1ns/100ps
module tx_frame_sync_port_tb;
    import txport_pkg::*;
    // ========================================
    // Signals and instances
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic fs = 1'b0;
    logic lbit = 1'b0;
    logic pin = 1'b0;
    logic [2:0] sel = 3'h0;
    logic inv = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [4:0] pol = 5'h00;
    logic [31:0] rdata;
    logic [4:0] rclk;
    logic samp_clk, mask, pay, frac, fen, oclk, od, oen, dout, mout, osof, fsof, pb, pv, fb, fv, lb, lv, lt;
    logic pe_q[$], po_q[$], fe_q[$], fo_q[$], le_q[$];
    logic [1:0] lo_q[$];
    logic mh[64];
    logic lh[64];
    logic dexp;
    int errors = 0;
    int num_checks = 0;
    int sofs = 0;
    int takes = 0;
    tx_port_partner u_far (.sel(sel), .inv(inv), .rclk(rclk), .samp_clk(samp_clk), .mask(mask), .pay(pay),
        .frac(frac), .fen(fen), .oclk(oclk), .od(od), .oen(oen));
    tx_frame_sync_port u_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .tx_clk_in(rclk[0]), .tx_line_clk(rclk[1]),
        .tx_clk_out(rclk[2]), .rx_clk_out(rclk[3]), .rx_line_clk(rclk[4]), .tx_frame_start_in(fs),
        .tx_ovh_mask_in(mask), .tx_serial_payload_in(pay), .tx_plcp_ovh_in(od), .tx_frac_ovh_in(frac),
        .tx_plcp_ovh_enable(oen), .tx_frac_ovh_enable_in(fen), .tx_line_data_out(dout),
        .tx_ovh_mask_out(mout), .tx_plcp_ovh_clk(oclk), .tx_plcp_ovh_sof_out(osof), .line_bit_in(lbit),
        .plcp_bit_in(pin), .line_bit_take(lt), .frame_sof(fsof), .payload_bit(pb), .payload_valid(pv),
        .frac_bit(fb), .frac_valid(fv), .plcp_bit_out(lb), .plcp_valid(lv));
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    // Expected streams come from the pins at each sampling edge; observed ones from the valids.
    always @(posedge samp_clk) begin
        if (mode == 3'h4) pe_q.push_back(pay ^ pol[2]);
        if (mode == 3'h2 || (mode == 3'h3 && fen)) fe_q.push_back(frac ^ pol[4]);
    end
    always @(posedge ref_clk) begin
        if (pv) po_q.push_back(pb);
        if (fv) fo_q.push_back(fb);
        if (lv) lo_q.push_back({osof, lb});
        if (fsof) sofs++;
        if (lt) takes++;
    end
    always @(negedge oclk) begin
        le_q.push_back(oen ? od ^ pol[3] : pin);
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        stop_test();
    end
    // ========================================
    // Tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge ref_clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge ref_clk);
        rd_s <= 1'b0;
        @(negedge ref_clk);
        d = rdata;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_bit(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic cmp_q(input string n, ref logic e[$], ref logic o[$]);
        chk(n, 32'(e.size()), 32'(o.size()));
        for (int i = 0; i < e.size() && i < o.size(); i++) chk_bit(n, e[i], o[i]);
    endtask
    task automatic cfg(input logic [2:0] m, input logic en, input logic [2:0] s, input logic iv, input logic [4:0] p);
        wr(POL_OFS, {27'h0, p});
        wr(CTRL_OFS, {24'h0, iv, s, en, m});
        mode = m;
        pol = p;
        sel = s;
        inv = iv;
    endtask
    // Clearing well after a sampling edge keeps expected and observed streams aligned.
    task automatic clr();
        @(posedge samp_clk);
        #700;
        pe_q.delete();
        po_q.delete();
        fe_q.delete();
        fo_q.delete();
    endtask
    task automatic ticks(input int n, input logic overhead_masked_mode, input logic [1:0] fm);
        logic b;
        int tk0;
        dexp = 1'bx;
        for (int j = 0; j < n; j++) begin
            @(posedge samp_clk);
            mh[j] = mask ^ pol[1];
            if (j >= 4 && !(overhead_masked_mode && mh[j-4])) dexp = lh[j-1];
            if (j >= 6) chk_bit("mask_out", overhead_masked_mode & mh[j-4], mout);
            if (j >= 6 && dexp !== 1'bx) chk_bit("line_data", dexp, dout);
            if (j >= 6) chk("line_take", 32'(!(overhead_masked_mode && mh[j-4])), 32'(takes - tk0));
            tk0 = takes;
            b = 1'($urandom);
            @(posedge ref_clk);
            lbit <= b;
            fs <= (fm == 2'd2 ? j[0] : fm[0]) ^ pol[0];
            lh[j] = b;
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ========================================
    // Tests
    initial begin
        logic [31:0] v;
        logic [31:0] a0;
        int s0;
        void'($urandom(46));
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(i == 4 ? 8'h18 : 8'(i * 4), v);
            chk("reg_reset", i == 2 ? 32'h100 : (i == 3 ? 32'h10 : 32'h0), v);
        end
        wr(FLEN_OFS, 32'h0);
        rd(FLEN_OFS, v);
        chk("flen_clamp", 32'h1, v);
        wr(POL_OFS, 32'hffffffff);
        rd(POL_OFS, v);
        chk("pol_width", 32'h1f, v);
        $display("Done registers");
        for (int m = 0; m < 2; m++) begin
            wr(FLEN_OFS, 32'h8);
            cfg(m ? 3'h2 : 3'h0, 1'b1, 3'h0, 1'b0, 5'(m));
            ticks(6, 1'b0, 2'd0);
            rd(ACNT_OFS, a0);
            ticks(1, 1'b0, 2'd1);
            @(posedge samp_clk);
            repeat (6) @(posedge ref_clk);
            rd(STAT_OFS, v);
            chk("frame_pos", 32'h0, v);
            rd(ACNT_OFS, v);
            chk("align_cnt", {16'h0, a0[15:0] + 16'h1}, v);
            s0 = sofs;
            ticks(32, 1'b0, 2'd1);
            repeat (6) @(posedge ref_clk);
            chk("sof_high", 32'd4, 32'(sofs - s0));
            s0 = sofs;
            ticks(16, 1'b0, 2'd0);
            repeat (6) @(posedge ref_clk);
            chk("sof_low", 32'd2, 32'(sofs - s0));
            rd(ACNT_OFS, v);
            chk("align_cnt", {16'h0, a0[15:0] + 16'h1}, v);
            $display("Done frame align %0d", m);
        end
        cfg(3'h1, 1'b1, 3'h0, 1'b0, 5'h02);
        rd(ACNT_OFS, a0);
        ticks(40, 1'b1, 2'd2);
        rd(ACNT_OFS, v);
        chk("align_cnt_masked", a0, v);
        $display("Done mask");
        for (int k = 0; k < 10; k++) begin
            cfg(k % 3 == 0 ? 3'h4 : (k % 3 == 1 ? 3'h2 : 3'h3), 1'b1, 3'(k / 2), k[0], 5'($urandom));
            clr();
            repeat (10) @(posedge samp_clk);
            #700;
            cmp_q("payload", pe_q, po_q);
            cmp_q("frac", fe_q, fo_q);
        end
        $display("Done streams");
        wr(PLEN_OFS, 32'h4);
        pin <= 1'($urandom);
        le_q.delete();
        lo_q.delete();
        cfg(3'h5, 1'b1, 3'h0, 1'b0, 5'h08);
        repeat (12) @(negedge oclk);
        repeat (2) @(posedge ref_clk);
        chk("plcp_count", 32'd12, 32'(lo_q.size()));
        for (int i = 0; i < 12; i++) begin
            chk_bit("plcp_bit", le_q[i], lo_q[i][0]);
            chk_bit("plcp_sof", i % 4 == 3, lo_q[i][1]);
        end
        cfg(3'h5, 1'b0, 3'h0, 1'b0, 5'h00);
        repeat (3) @(posedge ref_clk);
        for (int i = 0; i < 16; i++) begin
            @(negedge ref_clk);
            chk_bit("ovh_clk_off", 1'b0, oclk);
        end
        $display("Done plcp");
        stop_test();
    end
endmodule
